// File: core/asx_core.sv
// Subtract/swap/xor instruction datapath with its AHB-Lite register slave
//
// The AHB-Lite interface to the registers and the address map were decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "asx_regs.svh"

// Notes on behaviour
// RULE1 - Literal minus accumulator goes to accumulator; carry, half carry, zero updated.
// RULE2 - File minus accumulator minus inverted carry; carry, half carry, zero updated.
// RULE3 - Borrow subtract result goes to accumulator on dest 0, file on 1.
// RULE4 - Nibble exchange of file into accumulator or file; flags unchanged.
// RULE5 - Accumulator loads port A, B or C direction for operand 5, 6, 7.
// RULE6 - Accumulator xor literal into accumulator; only zero flag updated.
// RULE7 - Accumulator xor file into accumulator or file by dest; only zero updated.
// RULE8 - Zero flag set when an arithmetic or logic result is zero, else cleared.
module asx_core import asx_pkg::*; (
   // Clock and reset
   input  wire logic        sys_clk,
   input  wire logic        resetn,
   // AHB-Lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic  [1:0] htrans,
   input  wire logic        hwrite,
   input  wire logic  [2:0] hsize,
   input  wire logic        hready,
   input  wire logic [31:0] hwdata,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   // Port direction registers
   output logic       [7:0] port_a_direction,
   output logic       [7:0] port_b_direction,
   output logic       [7:0] port_c_direction
);

   // Register word match on the low address byte, upper bits must be zero
   function automatic logic is_reg(input logic [31:0] addr, input logic [7:0] off);
      is_reg = (addr[31:8] == 24'h000000) && (addr[7:0] == off);
   endfunction

   logic               a_valid_ff;
   logic               a_write_ff;
   logic        [31:0] a_addr_ff;
   logic        [31:0] rdata_ff;
   logic        [31:0] nxt_rdata;
   asx_cmd_type        cmd_ff;
   asx_cmd_type        nxt_cmd;
   logic         [7:0] acc_ff;
   asx_flags_type      flags_ff;
   logic         [6:0] faddr_ff;
   logic         [7:0] file_mem [0:`ASX_FILE_DEPTH-1];
   logic         [7:0] dir_ff [0:2];
   logic               wr_en;
   logic               exec;
   logic         [7:0] fval;
   asx_alu_out_type    alu_out;

   // Zero-wait, always OKAY slave; transfer size is not checked, whole words assumed
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign hrdata    = rdata_ff;

   // Address phase capture
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         a_valid_ff <= 1'b0;
         a_write_ff <= 1'b0;
         a_addr_ff  <= 32'h00000000;
      end else begin
         a_valid_ff <= hsel & hready & htrans[1];
         a_write_ff <= hwrite;
         a_addr_ff  <= haddr;
      end
   end

   // Data phase write strobe; a command write executes in that same cycle
   assign wr_en   = a_valid_ff & a_write_ff;
   assign exec    = wr_en & is_reg(a_addr_ff, `ASX_CMD_OFF);
   assign nxt_cmd = asx_cmd_type'(hwdata[$bits(asx_cmd_type)-1:0]);
   assign fval    = file_mem[nxt_cmd.faddr];

   asx_alu u_alu (
      .op      (nxt_cmd.op),
      .dest    (nxt_cmd.dest),
      .faddr   (nxt_cmd.faddr),
      .literal (nxt_cmd.literal),
      .acc     (acc_ff),
      .fval    (fval),
      .flags   (flags_ff),
      .alu_out (alu_out)
   );

   // Last command word, kept for read-back
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         cmd_ff <= '0;
      end else if (exec) begin
         cmd_ff <= nxt_cmd;
      end
   end

   // Accumulator: instruction result beats a register write, both never in one cycle
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         acc_ff <= `ASX_ACC_RST;
      end else if (exec && alu_out.to_acc) begin
         acc_ff <= alu_out.result; // see RULE1
      end else if (wr_en && is_reg(a_addr_ff, `ASX_ACC_OFF)) begin
         acc_ff <= hwdata[7:0];
      end
   end

   // Flags: the unit passes untouched flags through unchanged
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         flags_ff <= '0;
      end else if (exec) begin
         flags_ff <= alu_out.flags; // see RULE8
      end else if (wr_en && is_reg(a_addr_ff, `ASX_STATUS_OFF)) begin
         flags_ff.carry           <= hwdata[`ASX_ST_CARRY];
         flags_ff.half_carry_flag <= hwdata[`ASX_ST_HALF];
         flags_ff.zero            <= hwdata[`ASX_ST_ZERO];
      end
   end

   // Software pointer into the file
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         faddr_ff <= 7'h00;
      end else if (wr_en && is_reg(a_addr_ff, `ASX_FADDR_OFF)) begin
         faddr_ff <= hwdata[6:0];
      end
   end

   // File registers hold data only, so they carry no reset
   always_ff @(posedge sys_clk) begin
      if (exec && alu_out.to_file) begin
         file_mem[nxt_cmd.faddr] <= alu_out.result; // see RULE3
      end else if (wr_en && is_reg(a_addr_ff, `ASX_FDATA_OFF)) begin
         file_mem[faddr_ff] <= hwdata[7:0];
      end
   end

   // Port direction registers
   generate
      for (genvar i = 0; i < 3; i++) begin : g_dir
         always_ff @(posedge sys_clk) begin
            if (!resetn) begin
               dir_ff[i] <= `ASX_DIR_RST;
            end else if (exec && alu_out.dir_we[i]) begin
               dir_ff[i] <= acc_ff; // see RULE5
            end
         end
      end
   endgenerate

   assign port_a_direction = dir_ff[0];
   assign port_b_direction = dir_ff[1];
   assign port_c_direction = dir_ff[2];

   // Read data chosen in the address phase; a read right after a write sees old data
   always_comb begin
      nxt_rdata = 32'h00000000;
      if (is_reg(haddr, `ASX_CMD_OFF)) begin
         nxt_rdata = {13'h0000, cmd_ff};
      end else if (is_reg(haddr, `ASX_ACC_OFF)) begin
         nxt_rdata = {24'h000000, acc_ff};
      end else if (is_reg(haddr, `ASX_STATUS_OFF)) begin
         nxt_rdata = {29'h00000000, flags_ff};
      end else if (is_reg(haddr, `ASX_FADDR_OFF)) begin
         nxt_rdata = {25'h0000000, faddr_ff};
      end else if (is_reg(haddr, `ASX_FDATA_OFF)) begin
         nxt_rdata = {24'h000000, file_mem[faddr_ff]};
      end else if (is_reg(haddr, `ASX_PORTDIR_OFF)) begin
         nxt_rdata = {8'h00, dir_ff[2], dir_ff[1], dir_ff[0]};
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         rdata_ff <= 32'h00000000;
      end else if (hsel && hready && htrans[1] && !hwrite) begin
         rdata_ff <= nxt_rdata;
      end
   end

   // Helper views of the executing command for the checks below
   logic [2:0] ex_op;
   logic       ex_dest;
   logic [6:0] ex_faddr;
   logic [7:0] ex_lit;
   logic [3:0] fval_lo;
   logic [3:0] fval_hi;
   logic [7:0] ref_res;
   assign ex_op    = nxt_cmd.op;
   assign ex_dest  = nxt_cmd.dest;
   assign ex_faddr = nxt_cmd.faddr;
   assign ex_lit   = nxt_cmd.literal;
   assign fval_lo  = fval[3:0];
   assign fval_hi  = fval[7:4];
   // Result rebuilt from the operands, so the zero check does not just echo the unit
   assign ref_res  = (ex_op == op_sub_acc_from_literal) ? ex_lit - acc_ff :
                     (ex_op == op_sub_with_borrow_from_file) ?
                        fval - acc_ff - {7'h00, ~flags_ff.carry} :
                     (ex_op == op_xor_literal_into_acc) ? acc_ff ^ ex_lit : acc_ff ^ fval;

   a_sub_acc_from_literal_result: assert property (@(posedge sys_clk) disable iff (!resetn) // see RULE1
      exec && ex_op == op_sub_acc_from_literal |=>
         acc_ff == 8'($past(ex_lit) - $past(acc_ff)) &&
         flags_ff.carry == ($past(acc_ff) <= $past(ex_lit)))
      else $error("literal subtract result or carry wrong");

   a_swb_carry: assert property (@(posedge sys_clk) disable iff (!resetn) // see RULE2
      exec && ex_op == op_sub_with_borrow_from_file |=>
         flags_ff.carry == ({1'b0, $past(fval)} >=
                            {1'b0, $past(acc_ff)} + {8'h00, ~$past(flags_ff.carry)}))
      else $error("borrow subtract carry wrong");

   a_swb_dest_file: assert property (@(posedge sys_clk) disable iff (!resetn) // see RULE3
      exec && ex_op == op_sub_with_borrow_from_file && ex_dest |=> $stable(acc_ff))
      else $error("borrow subtract to file touched accumulator");

   a_swap_acc: assert property (@(posedge sys_clk) disable iff (!resetn) // see RULE4
      exec && ex_op == op_nibble_exchange && !ex_dest |=>
         acc_ff == {$past(fval_lo), $past(fval_hi)} && $stable(flags_ff))
      else $error("nibble exchange wrong");

   a_dir_load_a: assert property (@(posedge sys_clk) disable iff (!resetn) // see RULE5
      exec && ex_op == op_port_direction_load && ex_faddr == `ASX_DIR_A_SEL |=>
         port_a_direction == $past(acc_ff) && $stable(port_b_direction) && $stable(flags_ff))
      else $error("port direction load wrong");

   a_xor_literal_into_acc_flags: assert property (@(posedge sys_clk) disable iff (!resetn) // see RULE6
      exec && ex_op == op_xor_literal_into_acc |=>
         acc_ff == ($past(ex_lit) ^ $past(acc_ff)) && $stable(flags_ff.carry) &&
         $stable(flags_ff.half_carry_flag))
      else $error("literal xor wrong");

   a_xor_acc_with_file_acc: assert property (@(posedge sys_clk) disable iff (!resetn) // see RULE7
      exec && ex_op == op_xor_acc_with_file && !ex_dest |=>
         acc_ff == ($past(fval) ^ $past(acc_ff)) && $stable(flags_ff.carry))
      else $error("file xor wrong");

   a_zero_flag: assert property (@(posedge sys_clk) disable iff (!resetn) // see RULE8
      exec && (ex_op == op_sub_acc_from_literal || ex_op == op_sub_with_borrow_from_file ||
               ex_op == op_xor_literal_into_acc || ex_op == op_xor_acc_with_file) |=>
         flags_ff.zero == ($past(ref_res) == 8'h00))
      else $error("zero flag wrong");

endmodule // asx_core
`default_nettype wire

// File: include/asx_regs.svh
// Register offsets, field values and reset values of the subtract/swap/xor datapath
`ifndef ASX_REGS_SVH
`define ASX_REGS_SVH

// Byte offsets of the AHB-Lite register words
`define ASX_CMD_OFF      8'h00
`define ASX_ACC_OFF      8'h04
`define ASX_STATUS_OFF   8'h08
`define ASX_FADDR_OFF    8'h0c
`define ASX_FDATA_OFF    8'h10
`define ASX_PORTDIR_OFF  8'h14

// Status word bit positions
`define ASX_ST_CARRY     0
`define ASX_ST_HALF      1
`define ASX_ST_ZERO      2

// Operands of the port direction load
`define ASX_DIR_A_SEL    7'h05
`define ASX_DIR_B_SEL    7'h06
`define ASX_DIR_C_SEL    7'h07

// Reset values and file depth
`define ASX_ACC_RST      8'h00
`define ASX_DIR_RST      8'hff
`define ASX_FILE_DEPTH   128

`endif

// File: include/asx_pkg.sv
// Types shared by the subtract/swap/xor datapath files
`default_nettype none

package asx_pkg;

   // Instruction codes carried in the command word
   typedef enum logic [2:0] {
      op_sub_acc_from_literal     = 3'b000,
      op_sub_with_borrow_from_file = 3'b001,
      op_nibble_exchange          = 3'b010,
      op_port_direction_load      = 3'b011,
      op_xor_literal_into_acc     = 3'b100,
      op_xor_acc_with_file        = 3'b101
   } asx_op_type;

   // Command word layout, low bits last
   typedef struct packed {
      logic [7:0] literal;
      logic [6:0] faddr;
      logic       dest;
      logic [2:0] op;
   } asx_cmd_type;

   // Status flags
   typedef struct packed {
      logic zero;
      logic half_carry_flag;
      logic carry;
   } asx_flags_type;

   // Datapath answer for one instruction
   typedef struct packed {
      logic [7:0]    result;
      asx_flags_type flags;
      logic          to_acc;
      logic          to_file;
      logic [2:0]    dir_we;
   } asx_alu_out_type;

endpackage

`default_nettype wire

// File: core/asx_alu.sv
// Combinational arithmetic and logic unit of the subtract/swap/xor datapath
`timescale 1ns/100ps
`default_nettype none
`include "asx_regs.svh"

module asx_alu import asx_pkg::*; (
   // Decoded instruction
   input  wire logic            [2:0] op,
   input  wire logic                  dest,
   input  wire logic            [6:0] faddr,
   input  wire logic            [7:0] literal,
   // Operands and current flags
   input  wire logic            [7:0] acc,
   input  wire logic            [7:0] fval,
   input  wire asx_flags_type         flags,
   // Answer
   output asx_alu_out_type            alu_out
);

   logic [7:0] minuend;
   logic       borrow_in_n;
   logic [8:0] full_sum;
   logic [4:0] low_sum;

   // Subtract as minuend + ~acc + carry-in; carry out means no borrow
   always_comb begin
      minuend     = (op == op_sub_acc_from_literal) ? literal : fval;
      borrow_in_n = (op == op_sub_with_borrow_from_file) ? flags.carry : 1'b1; // see RULE2
      full_sum    = {1'b0, minuend} + {1'b0, ~acc} + {8'h00, borrow_in_n};
      low_sum     = {1'b0, minuend[3:0]} + {1'b0, ~acc[3:0]} + {4'h0, borrow_in_n};
   end

   // Result, flag and destination selection
   always_comb begin
      alu_out         = '0;
      alu_out.flags   = flags;
      unique case (op)
         op_sub_acc_from_literal: begin
            alu_out.result                = full_sum[7:0]; // see RULE1
            alu_out.flags.carry           = full_sum[8];
            alu_out.flags.half_carry_flag = low_sum[4];
            alu_out.flags.zero            = (full_sum[7:0] == 8'h00); // see RULE8
            alu_out.to_acc                = 1'b1;
         end
         op_sub_with_borrow_from_file: begin
            alu_out.result                = full_sum[7:0]; // see RULE2
            alu_out.flags.carry           = full_sum[8];
            alu_out.flags.half_carry_flag = low_sum[4];
            alu_out.flags.zero            = (full_sum[7:0] == 8'h00); // see RULE8
            alu_out.to_acc                = ~dest; // see RULE3
            alu_out.to_file               = dest;
         end
         op_nibble_exchange: begin
            alu_out.result  = {fval[3:0], fval[7:4]}; // see RULE4
            alu_out.to_acc  = ~dest;
            alu_out.to_file = dest;
         end
         op_port_direction_load: begin
            // Operands outside 5..7 load nothing
            alu_out.result = acc;
            alu_out.dir_we = {faddr == `ASX_DIR_C_SEL, faddr == `ASX_DIR_B_SEL,
                              faddr == `ASX_DIR_A_SEL}; // see RULE5
         end
         op_xor_literal_into_acc: begin
            alu_out.result     = acc ^ literal; // see RULE6
            alu_out.flags.zero = ((acc ^ literal) == 8'h00); // see RULE8
            alu_out.to_acc     = 1'b1;
         end
         op_xor_acc_with_file: begin
            alu_out.result     = acc ^ fval; // see RULE7
            alu_out.flags.zero = ((acc ^ fval) == 8'h00); // see RULE8
            alu_out.to_acc     = ~dest;
            alu_out.to_file    = dest;
         end
         default: begin
            // Unused codes change nothing
            alu_out.result = acc;
         end
      endcase
   end

endmodule // asx_alu
`default_nettype wire

// File: testbench/asx_ahb_master.sv
// Partner model: AHB-Lite master issuing single-word register transfers
`timescale 1ns/100ps
`default_nettype none

module asx_ahb_master (
   // Clock and bus answer
   input  wire logic        sys_clk,
   input  wire logic        hready,
   input  wire logic [31:0] hrdata,
   // Bus request
   output logic             hsel,
   output logic      [31:0] haddr,
   output logic       [1:0] htrans,
   output logic             hwrite,
   output logic       [2:0] hsize,
   output logic      [31:0] hwdata
);
   // Idle bus from time zero, whole-word size only
   initial begin
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'b010;
      hwdata = 32'h0;
   end

   // One transfer; read data taken at the edge that ends the data phase
   task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] wd,
                       output logic [31:0] q);
      @(posedge sys_clk);
      hsel   <= 1'b1;
      haddr  <= a;
      htrans <= 2'b10;
      hwrite <= w;
      do @(posedge sys_clk); while (hready !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'b00;
      // Reads put a changing pattern on hwdata so stale data never looks valid
      hwdata <= w ? wd : ~hwdata;
      do @(posedge sys_clk); while (hready !== 1'b1);
      q = hrdata;
   endtask
endmodule // asx_ahb_master
`default_nettype wire

// File: testbench/alu_sub_swap_xor_ops_test.sv
// Self-checking bench of the subtract/swap/xor datapath against an integer model
`timescale 1ns/100ps
`default_nettype none
`include "asx_regs.svh"

module alu_sub_swap_xor_ops_test;
   logic        sys_clk = 1'b0;
   logic        resetn = 1'b0;
   logic        hsel, hwrite, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata, rdv;
   logic  [1:0] htrans;
   logic  [2:0] hsize;
   logic  [7:0] dir_a, dir_b, dir_c;
   int          err_count = 0, n_compared = 0, cyc = 0;
   int          acc, c, hc, z, f, r, op, d, fa, lit, b;
   int          da = 255, db = 255, dk = 255;

   // Free-running 125 MHz clock
   initial forever #4 sys_clk = ~sys_clk;

   asx_ahb_master m (.sys_clk(sys_clk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

   asx_core dut (.sys_clk(sys_clk), .resetn(resetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout),
      .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .port_a_direction(dir_a), .port_b_direction(dir_b), .port_c_direction(dir_c));

   task automatic final_report();
      if (err_count == 0 && n_compared > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         err_count++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input int v);
      m.xfer(1'b1, {24'h0, a}, v[31:0], rdv);
   endtask

   task automatic rd(input logic [7:0] a, input int v);
      m.xfer(1'b0, {24'h0, a}, 32'h0, rdv);
      chk(rdv, v[31:0]);
   endtask

   // Hang guard, well above the ~10k cycles the run needs
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 30000) begin
         err_count++;
         final_report();
      end
   end

   initial begin
      void'($urandom(32'h66c8));
      repeat (6) @(posedge sys_clk);
      resetn <= 1'b1;
      rd(`ASX_PORTDIR_OFF, 32'h00ffffff);
      rd(`ASX_ACC_OFF, 0);
      rd(`ASX_STATUS_OFF, 0);
      // Unmapped word: write dropped, read gives zero
      wr(8'h18, 32'h5a);
      rd(8'h18, 0);
      chk({31'h0, hresp}, 0);
      chk({31'h0, hreadyout}, 1);
      repeat (300) begin
         op = $urandom % 8;
         d = $urandom % 2;
         lit = $urandom % 256;
         fa = (op == 3) ? 4 + $urandom % 4 : $urandom % 128;
         f = $urandom % 256;
         acc = $urandom % 256;
         // About one case in four, drawn at random, forces equal operands: zero results and carry boundary
         if ($urandom % 4 == 0) acc = (op == 0 || op == 4) ? lit : f;
         c = $urandom % 2;
         hc = $urandom % 2;
         z = $urandom % 2;
         wr(`ASX_FADDR_OFF, fa);
         wr(`ASX_FDATA_OFF, f);
         wr(`ASX_ACC_OFF, acc);
         wr(`ASX_STATUS_OFF, z * 4 + hc * 2 + c);
         wr(`ASX_CMD_OFF, lit * 2048 + fa * 16 + d * 8 + op);
         // Reference model of the executed instruction
         case (op)
            0: begin
               r = lit - acc;
               c = acc <= lit;
               hc = acc % 16 <= lit % 16;
               acc = r & 255;
               z = acc == 0;
            end
            1: begin
               b = 1 - c;
               r = f - acc - b;
               c = r >= 0;
               hc = f % 16 - acc % 16 - b >= 0;
               r = r & 255;
               z = r == 0;
               if (d) f = r; else acc = r;
            end
            2: begin
               r = f % 16 * 16 + f / 16;
               if (d) f = r; else acc = r;
            end
            3: case (fa)
               5: da = acc;
               6: db = acc;
               7: dk = acc;
               default: ;
            endcase
            4: begin
               acc = acc ^ lit;
               z = acc == 0;
            end
            5: begin
               r = acc ^ f;
               z = r == 0;
               if (d) f = r; else acc = r;
            end
            default: ;
         endcase
         rd(`ASX_ACC_OFF, acc);
         rd(`ASX_STATUS_OFF, z * 4 + hc * 2 + c);
         rd(`ASX_FDATA_OFF, f);
         rd(`ASX_PORTDIR_OFF, dk * 65536 + db * 256 + da);
         chk({8'h0, dir_c, dir_b, dir_a}, dk * 65536 + db * 256 + da);
         rd(`ASX_CMD_OFF, lit * 2048 + fa * 16 + d * 8 + op);
      end
      final_report();
   end
endmodule // alu_sub_swap_xor_ops_test
`default_nettype wire
